// File: inc/adsc_pkg.sv
// Shared constants for the antenna driver segment control block
package adsc_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADSC_SEG_W  = 8;
	localparam int ADSC_CODE_W = 6;
	localparam int ADSC_ADDR_W = 12;
	localparam int ADSC_DATA_W = 32;

	// ----------------------------------------------------------------
	// Register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [7:0] ADSC_IDX_DEPTH_CTRL = 8'h24;
	localparam logic [7:0] ADSC_IDX_DEPTH_RES  = 8'h25;
	localparam logic [7:0] ADSC_IDX_MOD_MASK   = 8'h26;
	localparam logic [7:0] ADSC_IDX_NORM_MASK  = 8'h27;
	localparam logic [7:0] ADSC_IDX_IRQ_STAT   = 8'h30;
	localparam logic [7:0] ADSC_IDX_IRQ_MASK   = 8'h31;

	// ----------------------------------------------------------------
	// Field positions of the depth control register
	// ----------------------------------------------------------------
	localparam int ADSC_SRC_SEL_BIT = 7;
	localparam int ADSC_CODE_MSB    = 6;
	localparam int ADSC_CODE_LSB    = 1;

	// ----------------------------------------------------------------
	// Interrupt status bit positions
	// ----------------------------------------------------------------
	localparam int ADSC_IRQ_CAL_DONE = 0;
	localparam int ADSC_IRQ_CAL_ERR  = 1;
	localparam int ADSC_IRQ_W        = 2;

	// ----------------------------------------------------------------
	// Values after reset and special patterns
	// ----------------------------------------------------------------
	localparam logic [7:0] ADSC_RST_DEPTH_CTRL = 8'h00;
	localparam logic [7:0] ADSC_RST_DEPTH_RES  = 8'h00;
	localparam logic [7:0] ADSC_RST_MOD_MASK   = 8'h00;
	localparam logic [7:0] ADSC_RST_NORM_MASK  = 8'h00;
	localparam logic [1:0] ADSC_RST_IRQ        = 2'h0;
	localparam logic [7:0] ADSC_CAL_FAIL_VALUE = 8'hFF;
	localparam logic [7:0] ADSC_ALL_OFF        = 8'hFF;

	// ----------------------------------------------------------------
	// Segment weights in ohm, bit 7 strongest
	// ----------------------------------------------------------------
	localparam int ADSC_OHM_BIT7 = 2;
	localparam int ADSC_OHM_BIT0 = 256;

	// Byte address of a register index
	function automatic logic [ADSC_ADDR_W-1:0] adsc_byte_addr(input logic [7:0] idx);
		adsc_byte_addr = {2'h0, idx, 2'h0};
	endfunction

endpackage

// File: design/adsc_cal_result.sv
// Calibration result holder for the antenna driver segment control block
`timescale 1ns/1ns
module adsc_cal_result
	import adsc_pkg::*;
#(
	parameter int SEG_W = ADSC_SEG_W
) (
	input  wire logic             clk_i,    // System clock
	input  wire logic             rst_i,    // Synchronous reset, high
	input  wire logic             clr_i,    // Restore defaults pulse
	input  wire logic             done_i,   // Calibration finished pulse
	input  wire logic             pass_i,   // Calibration succeeded
	input  wire logic [SEG_W-1:0] seg_i,    // Calibrated disable pattern
	output logic      [SEG_W-1:0] result_o, // Result register
	output logic                  done_o,   // Done event pulse
	output logic                  err_o     // Error event pulse
);

	// ----------------------------------------------------------------
	// Result register
	// ----------------------------------------------------------------
	logic [SEG_W-1:0] result_ff;
	logic             done_ff;
	logic             err_ff;

	// Failure forces every segment off so a bad result never drives hard
	always_ff @(posedge clk_i) begin
		if (rst_i || clr_i) begin
			result_ff <= SEG_W'(ADSC_RST_DEPTH_RES); // RULE10
		end else if (done_i) begin
			result_ff <= pass_i ? seg_i : SEG_W'(ADSC_CAL_FAIL_VALUE); // RULE4
		end
	end

	// Event pulses, suppressed by a restore in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_ff <= 1'b0;
			err_ff  <= 1'b0;
		end else begin
			done_ff <= done_i && !clr_i;
			err_ff  <= done_i && !pass_i && !clr_i;
		end
	end

	assign result_o = result_ff; // RULE3
	assign done_o   = done_ff;
	assign err_o    = err_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_fail_all_ones;
		@(posedge clk_i) disable iff (rst_i)
		(done_i && !pass_i && !clr_i) |=> (result_ff == SEG_W'(ADSC_CAL_FAIL_VALUE)) && err_o;
	endproperty
	a_fail_all_ones: assert property (p_fail_all_ones) else $error("fail did not load all ones"); // RULE4

	property p_clear_zero;
		@(posedge clk_i) disable iff (rst_i)
		clr_i |=> (result_ff == '0) && !done_o;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("restore did not clear result"); // RULE10

endmodule

// File: design/adsc_top.sv
// Antenna driver segment control register bank with APB slave
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns

// What this block does
// RULE1: Source select 0 uses calibrated code
// RULE2: Source select 1 uses manual modulated mask
// RULE3: Calibration result shown in read-only register
// RULE4: Failed calibration loads result all ones
// RULE5: Manual mask one disables segment when modulated
// RULE6: Normal mask one disables segment normally
// RULE7: Bit seven strongest, bit zero weakest segment
// RULE8: Normal mask all ones tristates drivers
// RULE9: Control and masks reset to zero
// RULE10: Result register cleared on reset, restore
// RULE11: Output follows modulation state each change
module adsc_top
	import adsc_pkg::*;
#(
	parameter int SEG_W = ADSC_SEG_W
) (
	input  wire logic                   REF_CLK_I,      // 250 MHz clock
	input  wire logic                   RST_I,          // Synchronous reset, high
	input  wire logic                   PSEL_I,         // APB select
	input  wire logic                   PENABLE_I,      // APB access phase
	input  wire logic                   PWRITE_I,       // APB write
	input  wire logic [ADSC_ADDR_W-1:0] PADDR_I,        // APB byte address
	input  wire logic [ADSC_DATA_W-1:0] PWDATA_I,       // APB write data
	input  wire logic [3:0]             PSTRB_I,        // APB byte strobes
	output logic      [ADSC_DATA_W-1:0] PRDATA_O,       // APB read data
	output logic                        PREADY_O,       // APB ready
	output logic                        PSLVERR_O,      // APB error
	input  wire logic                   SET_DEFAULT_I,  // Restore defaults pulse
	input  wire logic                   CAL_DONE_I,     // Calibration done pulse
	input  wire logic                   CAL_PASS_I,     // Calibration passed
	input  wire logic [ADSC_CODE_W-1:0] CAL_CODE_I,     // Calibrated level code
	input  wire logic [SEG_W-1:0]       CAL_SEG_I,      // Calibrated disable pattern
	input  wire logic                   MOD_STATE_I,    // Transmitter modulated
	output logic      [SEG_W-1:0]       SEG_DISABLE_O,  // Segment disable vector
	output logic                        DRV_TRISTATE_O, // All segments off
	output logic                        IRQ_O           // Level interrupt
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]             depth_ctrl_ff;
	logic [SEG_W-1:0]       mod_mask_ff;
	logic [SEG_W-1:0]       norm_mask_ff;
	logic [SEG_W-1:0]       cal_result;
	logic [ADSC_IRQ_W-1:0]  irq_stat_ff;
	logic [ADSC_IRQ_W-1:0]  irq_mask_ff;
	logic [ADSC_IRQ_W-1:0]  rd_stat_ff;
	logic [ADSC_DATA_W-1:0] prdata_ff;
	logic [SEG_W-1:0]       seg_ff;
	logic                   tristate_ff;
	logic [SEG_W-1:0]       nxt_seg;
	logic [7:0]             rd_mux;
	logic                   hit;
	logic                   setup_rd;
	logic                   acc;
	logic                   wr_en;
	logic                   sel_ctrl;
	logic                   sel_res;
	logic                   sel_mod;
	logic                   sel_norm;
	logic                   sel_stat;
	logic                   sel_imsk;
	logic                   cal_done_evt;
	logic                   cal_err_evt;
	logic                   cal_load;
	logic [ADSC_IRQ_W-1:0]  irq_events;
	logic                   src_manual;

	// ----------------------------------------------------------------
	// Calibration result register
	// ----------------------------------------------------------------
	adsc_cal_result #(
		.SEG_W    (SEG_W)
	) u_cal_result (
		.clk_i    (REF_CLK_I),
		.rst_i    (RST_I),
		.clr_i    (SET_DEFAULT_I),
		.done_i   (CAL_DONE_I),
		.pass_i   (CAL_PASS_I),
		.seg_i    (CAL_SEG_I),
		.result_o (cal_result),
		.done_o   (cal_done_evt),
		.err_o    (cal_err_evt)
	);

	// ----------------------------------------------------------------
	// APB address decode
	// ----------------------------------------------------------------
	// Zero wait states; the slave never stalls the master
	assign acc      = PSEL_I && PENABLE_I;
	assign setup_rd = PSEL_I && !PENABLE_I && !PWRITE_I;
	assign wr_en    = acc && PWRITE_I && PSTRB_I[0];

	assign sel_ctrl = (PADDR_I == adsc_byte_addr(ADSC_IDX_DEPTH_CTRL));
	assign sel_res  = (PADDR_I == adsc_byte_addr(ADSC_IDX_DEPTH_RES));
	assign sel_mod  = (PADDR_I == adsc_byte_addr(ADSC_IDX_MOD_MASK));
	assign sel_norm = (PADDR_I == adsc_byte_addr(ADSC_IDX_NORM_MASK));
	assign sel_stat = (PADDR_I == adsc_byte_addr(ADSC_IDX_IRQ_STAT));
	assign sel_imsk = (PADDR_I == adsc_byte_addr(ADSC_IDX_IRQ_MASK));
	assign hit      = sel_ctrl || sel_res || sel_mod || sel_norm || sel_stat || sel_imsk;

	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = acc && !hit;

	// ----------------------------------------------------------------
	// Depth control register
	// ----------------------------------------------------------------
	// A passing calibration owns the code bits over a software write
	assign cal_load = CAL_DONE_I && CAL_PASS_I;

	always_ff @(posedge REF_CLK_I) begin
		if (RST_I || SET_DEFAULT_I) begin
			depth_ctrl_ff <= ADSC_RST_DEPTH_CTRL; // RULE9
		end else begin
			if (wr_en && sel_ctrl) begin
				depth_ctrl_ff[ADSC_SRC_SEL_BIT] <= PWDATA_I[ADSC_SRC_SEL_BIT];
			end
			if (cal_load) begin
				depth_ctrl_ff[ADSC_CODE_MSB:ADSC_CODE_LSB] <= CAL_CODE_I; // RULE1
			end else if (wr_en && sel_ctrl) begin
				depth_ctrl_ff[ADSC_CODE_MSB:ADSC_CODE_LSB] <= PWDATA_I[ADSC_CODE_MSB:ADSC_CODE_LSB];
			end
			depth_ctrl_ff[0] <= 1'b0;
		end
	end

	assign src_manual = depth_ctrl_ff[ADSC_SRC_SEL_BIT]; // RULE2

	// ----------------------------------------------------------------
	// Segment mask registers
	// ----------------------------------------------------------------
	// Manual modulated mask
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I || SET_DEFAULT_I) begin
			mod_mask_ff <= SEG_W'(ADSC_RST_MOD_MASK); // RULE9
		end else if (wr_en && sel_mod) begin
			mod_mask_ff <= PWDATA_I[SEG_W-1:0];
		end
	end

	// Normal level mask
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I || SET_DEFAULT_I) begin
			norm_mask_ff <= SEG_W'(ADSC_RST_NORM_MASK); // RULE9
		end else if (wr_en && sel_norm) begin
			norm_mask_ff <= PWDATA_I[SEG_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	assign irq_events = {cal_err_evt, cal_done_evt};

	// Clear only the bits that were returned, so a new event is never lost
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			irq_stat_ff <= ADSC_RST_IRQ;
		end else if (acc && !PWRITE_I && sel_stat) begin
			irq_stat_ff <= (irq_stat_ff & ~rd_stat_ff) | irq_events;
		end else begin
			irq_stat_ff <= irq_stat_ff | irq_events;
		end
	end

	// Interrupt mask, a one enables the source
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			irq_mask_ff <= ADSC_RST_IRQ;
		end else if (wr_en && sel_imsk) begin
			irq_mask_ff <= PWDATA_I[ADSC_IRQ_W-1:0];
		end
	end

	assign IRQ_O = |(irq_stat_ff & irq_mask_ff);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Read mux, unused upper bits return zero
	always_comb begin
		rd_mux = 8'h00;
		if (sel_ctrl) begin
			rd_mux = depth_ctrl_ff;
		end else if (sel_res) begin
			rd_mux = cal_result; // RULE3
		end else if (sel_mod) begin
			rd_mux = mod_mask_ff;
		end else if (sel_norm) begin
			rd_mux = norm_mask_ff;
		end else if (sel_stat) begin
			rd_mux = {6'h00, irq_stat_ff};
		end else if (sel_imsk) begin
			rd_mux = {6'h00, irq_mask_ff};
		end
	end

	// Captured in setup so the access phase sees flip-flop data
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			prdata_ff  <= '0;
			rd_stat_ff <= ADSC_RST_IRQ;
		end else if (setup_rd) begin
			prdata_ff  <= {24'h000000, rd_mux};
			rd_stat_ff <= sel_stat ? irq_stat_ff : ADSC_RST_IRQ;
		end
	end

	assign PRDATA_O = prdata_ff;

	// ----------------------------------------------------------------
	// Segment disable output
	// ----------------------------------------------------------------
	// Bit 7 drives the 2 ohm segment, bit 0 the 256 ohm one; no reordering
	always_comb begin
		nxt_seg = norm_mask_ff; // RULE6
		if (MOD_STATE_I) begin
			if (src_manual) begin
				nxt_seg = mod_mask_ff; // RULE5
			end else begin
				nxt_seg = cal_result; // RULE1
			end
		end
	end

	// One cycle of latency per state change, glitch free at the drivers
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			seg_ff      <= SEG_W'(ADSC_RST_NORM_MASK);
			tristate_ff <= 1'b0;
		end else begin
			seg_ff      <= nxt_seg; // RULE11
			tristate_ff <= (nxt_seg == SEG_W'(ADSC_ALL_OFF)); // RULE8
		end
	end

	assign SEG_DISABLE_O  = seg_ff; // RULE7
	assign DRV_TRISTATE_O = tristate_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_auto_source;
		@(posedge REF_CLK_I) disable iff (RST_I)
		(MOD_STATE_I && !src_manual) |=> (SEG_DISABLE_O == $past(cal_result));
	endproperty
	a_auto_source: assert property (p_auto_source) else $error("auto source not used"); // RULE1

	property p_manual_source;
		@(posedge REF_CLK_I) disable iff (RST_I)
		(MOD_STATE_I && src_manual) |=> (SEG_DISABLE_O == $past(mod_mask_ff));
	endproperty
	a_manual_source: assert property (p_manual_source) else $error("manual mask not used"); // RULE2

	property p_manual_bits;
		@(posedge REF_CLK_I) disable iff (RST_I)
		(MOD_STATE_I && src_manual && mod_mask_ff[SEG_W-1]) |=> SEG_DISABLE_O[SEG_W-1];
	endproperty
	a_manual_bits: assert property (p_manual_bits) else $error("manual strong bit ignored"); // RULE5

	property p_normal_source;
		@(posedge REF_CLK_I) disable iff (RST_I)
		!MOD_STATE_I |=> (SEG_DISABLE_O == $past(norm_mask_ff));
	endproperty
	a_normal_source: assert property (p_normal_source) else $error("normal mask not used"); // RULE6

	property p_tristate;
		@(posedge REF_CLK_I) disable iff (RST_I)
		(!MOD_STATE_I && norm_mask_ff == SEG_W'(ADSC_ALL_OFF)) |=> DRV_TRISTATE_O;
	endproperty
	a_tristate: assert property (p_tristate) else $error("all-off mask not tristate"); // RULE8

	property p_tristate_match;
		@(posedge REF_CLK_I) disable iff (RST_I)
		DRV_TRISTATE_O == (SEG_DISABLE_O == SEG_W'(ADSC_ALL_OFF));
	endproperty
	a_tristate_match: assert property (p_tristate_match) else $error("tristate flag mismatch"); // RULE8

	property p_restore;
		@(posedge REF_CLK_I) disable iff (RST_I)
		SET_DEFAULT_I |=> (depth_ctrl_ff == 8'h00) && (mod_mask_ff == '0) && (norm_mask_ff == '0);
	endproperty
	a_restore: assert property (p_restore) else $error("restore left nonzero"); // RULE9

	property p_code_load;
		@(posedge REF_CLK_I) disable iff (RST_I)
		(cal_load && !SET_DEFAULT_I) |=> (depth_ctrl_ff[ADSC_CODE_MSB:ADSC_CODE_LSB] == $past(CAL_CODE_I));
	endproperty
	a_code_load: assert property (p_code_load) else $error("code not updated"); // RULE1

	property p_result_view;
		@(posedge REF_CLK_I) disable iff (RST_I)
		(setup_rd && sel_res) |=> (PRDATA_O == {24'h000000, $past(cal_result)});
	endproperty
	a_result_view: assert property (p_result_view) else $error("result read wrong"); // RULE3

	property p_state_switch;
		@(posedge REF_CLK_I) disable iff (RST_I)
		($rose(MOD_STATE_I) && src_manual && !$changed(mod_mask_ff)) |=> SEG_DISABLE_O == $past(mod_mask_ff);
	endproperty
	a_state_switch: assert property (p_state_switch) else $error("no switch on modulation"); // RULE11

	property p_irq_level;
		@(posedge REF_CLK_I) disable iff (RST_I)
		cal_err_evt && irq_mask_ff[ADSC_IRQ_CAL_ERR] |=> IRQ_O;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("error interrupt missing");

	property p_result_readonly;
		@(posedge REF_CLK_I) disable iff (RST_I)
		(wr_en && sel_res && !CAL_DONE_I && !SET_DEFAULT_I) |=> $stable(cal_result);
	endproperty
	a_result_readonly: assert property (p_result_readonly) else $error("result register took a write"); // RULE3

	property p_src_write;
		@(posedge REF_CLK_I) disable iff (RST_I)
		(wr_en && sel_ctrl && !SET_DEFAULT_I) |=> (src_manual == $past(PWDATA_I[ADSC_SRC_SEL_BIT]));
	endproperty
	a_src_write: assert property (p_src_write) else $error("source select not written"); // RULE2

	property p_mod_write;
		@(posedge REF_CLK_I) disable iff (RST_I)
		(wr_en && sel_mod && !SET_DEFAULT_I) |=> (mod_mask_ff == $past(PWDATA_I[SEG_W-1:0]));
	endproperty
	a_mod_write: assert property (p_mod_write) else $error("modulated mask not written"); // RULE5

	property p_norm_write;
		@(posedge REF_CLK_I) disable iff (RST_I)
		(wr_en && sel_norm && !SET_DEFAULT_I) |=> (norm_mask_ff == $past(PWDATA_I[SEG_W-1:0]));
	endproperty
	a_norm_write: assert property (p_norm_write) else $error("normal mask not written"); // RULE6

	property p_tristate_off;
		@(posedge REF_CLK_I) disable iff (RST_I)
		(!MOD_STATE_I && norm_mask_ff != SEG_W'(ADSC_ALL_OFF)) |=> !DRV_TRISTATE_O;
	endproperty
	a_tristate_off: assert property (p_tristate_off) else $error("tristate with a segment on"); // RULE8

endmodule

// File: sim/tb_antenna_driver_segment_control.sv
// Self-checking testbench for the antenna driver segment control block
`timescale 1ns/1ns
module tb_antenna_driver_segment_control;
	import adsc_pkg::*;

	// ----------------------------------------------------------------
	// Byte addresses, kept local so stimulus does not lean on the package helper
	// ----------------------------------------------------------------
	localparam logic [11:0] A_CTRL = {2'h0, ADSC_IDX_DEPTH_CTRL, 2'h0};
	localparam logic [11:0] A_RES  = {2'h0, ADSC_IDX_DEPTH_RES, 2'h0};
	localparam logic [11:0] A_MOD  = {2'h0, ADSC_IDX_MOD_MASK, 2'h0};
	localparam logic [11:0] A_NORM = {2'h0, ADSC_IDX_NORM_MASK, 2'h0};
	localparam logic [11:0] A_IRQS = {2'h0, ADSC_IDX_IRQ_STAT, 2'h0};
	localparam logic [11:0] A_IRQM = {2'h0, ADSC_IDX_IRQ_MASK, 2'h0};
	localparam logic [11:0] A_HOLE = 12'h0A0;

	logic        ref_clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        set_default;
	logic        cal_done;
	logic        cal_pass;
	logic [5:0]  cal_code;
	logic [7:0]  cal_seg;
	logic        mod_state;
	logic [7:0]  seg_disable;
	logic        drv_tristate;
	logic        irq;
	logic [31:0] rd;
	logic        er;
	logic [11:0] regs [4];
	int          mismatches;
	int          tests_run;
	int          cycles;

	adsc_top i_adsc_top (
		.REF_CLK_I      (ref_clk),
		.RST_I          (rst),
		.PSEL_I         (psel),
		.PENABLE_I      (penable),
		.PWRITE_I       (pwrite),
		.PADDR_I        (paddr),
		.PWDATA_I       (pwdata),
		.PSTRB_I        (pstrb),
		.PRDATA_O       (prdata),
		.PREADY_O       (pready),
		.PSLVERR_O      (pslverr),
		.SET_DEFAULT_I  (set_default),
		.CAL_DONE_I     (cal_done),
		.CAL_PASS_I     (cal_pass),
		.CAL_CODE_I     (cal_code),
		.CAL_SEG_I      (cal_seg),
		.MOD_STATE_I    (mod_state),
		.SEG_DISABLE_O  (seg_disable),
		.DRV_TRISTATE_O (drv_tristate),
		.IRQ_O          (irq)
	);

	// ----------------------------------------------------------------
	// Clock, timeout and shared tasks
	// ----------------------------------------------------------------
	// 4 ns period
	initial ref_clk = 1'b0;
	always #2 ref_clk = ~ref_clk;

	// Cuts a hang short; the whole sequence needs well under 1000 cycles
	initial cycles = 0;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata, input logic [3:0] strb);
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= wdata;
		pstrb   <= strb;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] addr, input logic [7:0] data);
		apb(1'b1, addr, {24'h000000, data}, 4'hF);
	endtask

	task automatic rd_chk(input logic [11:0] addr, input logic [7:0] exp);
		apb(1'b0, addr, 32'h00000000, 4'hF);
		check(rd, {24'h000000, exp});
	endtask

	// Let n edges land, then look between edges
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic cal(input logic pass, input logic [5:0] code, input logic [7:0] seg);
		@(posedge ref_clk);
		cal_done <= 1'b1;
		cal_pass <= pass;
		cal_code <= code;
		cal_seg  <= seg;
		@(posedge ref_clk);
		cal_done <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		mismatches = 0;
		tests_run = 0;
		regs = '{A_CTRL, A_RES, A_MOD, A_NORM};
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		pstrb = 4'h0;
		set_default = 1'b0;
		cal_done = 1'b0;
		cal_pass = 1'b0;
		cal_code = 6'h00;
		cal_seg = 8'h00;
		mod_state = 1'b0;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		// Power-up values
		foreach (regs[i]) rd_chk(regs[i], 8'h00);
		check(seg_disable, 8'h00);
		// Access kinds: unused bit, ignored strobe, read-only result, unmapped hole
		wr(A_CTRL, 8'hFF);
		rd_chk(A_CTRL, 8'hFE);
		apb(1'b1, A_CTRL, 32'h00000000, 4'h0);
		rd_chk(A_CTRL, 8'hFE);
		wr(A_RES, 8'h55);
		rd_chk(A_RES, 8'h00);
		apb(1'b0, A_HOLE, 32'h00000000, 4'hF);
		check(er, 1'b1);
		check(rd, 32'h00000000);
		check(pready, 1'b1);
		// Normal state: the two strongest segments off, then all off
		wr(A_NORM, 8'hC0);
		settle(2);
		check(seg_disable, 8'hC0);
		check(drv_tristate, 1'b0);
		wr(A_NORM, 8'hFF);
		settle(2);
		check(seg_disable, 8'hFF);
		check(drv_tristate, 1'b1);
		// Passing calibration with automatic source, interrupt unmasked
		wr(A_CTRL, 8'h00);
		wr(A_IRQM, 8'h03);
		cal(1'b1, 6'h2A, 8'h5A);
		rd_chk(A_RES, 8'h5A);
		rd_chk(A_CTRL, 8'h54);
		check(irq, 1'b1);
		@(posedge ref_clk);
		mod_state <= 1'b1;
		settle(1);
		check(seg_disable, 8'h5A);
		check(drv_tristate, 1'b0);
		rd_chk(A_IRQS, 8'h01);
		settle(1);
		check(irq, 1'b0);
		// Manual source while modulated, then back to normal
		wr(A_MOD, 8'hBC);
		wr(A_CTRL, 8'h80);
		settle(2);
		check(seg_disable, 8'hBC);
		@(posedge ref_clk);
		mod_state <= 1'b0;
		settle(1);
		check(seg_disable, 8'hFF);
		// Failing calibration: all ones, code kept, both events
		cal(1'b0, 6'h15, 8'h0F);
		rd_chk(A_RES, 8'hFF);
		rd_chk(A_CTRL, 8'h80);
		rd_chk(A_IRQS, 8'h03);
		@(posedge ref_clk);
		mod_state <= 1'b1;
		settle(1);
		check(seg_disable, 8'hBC);
		wr(A_CTRL, 8'h00);
		settle(2);
		check(seg_disable, 8'hFF);
		// Restore defaults clears the bank but not the interrupt mask
		@(posedge ref_clk);
		set_default <= 1'b1;
		@(posedge ref_clk);
		set_default <= 1'b0;
		foreach (regs[i]) rd_chk(regs[i], 8'h00);
		rd_chk(A_IRQM, 8'h03);
		settle(1);
		check(seg_disable, 8'h00);
		wrap_up();
	end

endmodule
